// ### rtl/dhm_top.sv
// dhm_top: drive health monitor with link retry, error-rate monitor,
// thermal trip points and sense reporting, behind an apb slave.
// assumes all inputs synchronous to pclk; nv storage of pf_pending is outside.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ns
module dhm_top
    import dhm_pkg::*;
#(
    parameter logic [47:0] RETRY_CNT = RETRY_CYCLES,
    parameter logic [47:0] MEASURE_CNT = MEASURE_CYCLES,
    parameter logic [47:0] TEMP_CNT = TEMP_CYCLES,
    parameter logic [47:0] ONLINE_DELAY_CNT = ONLINE_DELAY_CYCLES,
    parameter logic [47:0] FULL_DELAY_CNT = FULL_DELAY_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic selftest_done,
    input wire logic selftest_fail_a,
    input wire logic selftest_fail_b,
    input wire logic sync_a,
    input wire logic sync_b,
    output logic link_reset_a,
    output logic link_reset_b,
    output logic link_oob,
    output logic respond_en_a,
    output logic respond_en_b,
    input wire logic host_idle,
    output logic measure_start,
    output logic measure_offline,
    input wire logic measure_done,
    input wire logic [N_ATTR-1:0] attr_op,
    input wire logic [N_ATTR-1:0] attr_err,
    output logic temp_sample_req,
    input wire logic temp_valid,
    input wire logic [7:0] temp_value,
    output logic frame_store_req,
    input wire logic pf_retained,
    output logic pf_pending,
    output logic sense_valid,
    output logic [15:0] sense_code,
    output logic [7:0] sense_fru
);

    // register bus and control state
    dhm_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] ref_temp_reg, ref_temp_next;
    logic round_flag_reg, round_flag_next;
    logic round_ev_reg, round_ev_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic rezero_reg, rezero_next;
    logic setup, acc, wr;
    logic [31:0] clr_st;

    // link state
    dhm_link_t lk_reg, lk_next;
    logic [47:0] retry_reg, retry_next;
    logic sel_b_reg, sel_b_next;
    logic fail_a_reg, fail_a_next, fail_b_reg, fail_b_next;
    logic lra_reg, lra_next, lrb_reg, lrb_next, oob_reg, oob_next;
    logic rea_reg, rea_next, reb_reg, reb_next;

    // measurement state
    dhm_meas_t ms_reg, ms_next;
    logic [47:0] mtimer_reg, mtimer_next;
    logic [47:0] mdelay_reg, mdelay_next;
    logic overrun_reg, overrun_next;
    logic mstart_reg, mstart_next, moff_reg, moff_next;

    // attribute state
    logic [N_ATTR-1:0][15:0] ivl_reg, ivl_next;
    logic [N_ATTR-1:0][15:0] fcnt_reg, fcnt_next;
    logic [N_ATTR-1:0][7:0] hist_reg, hist_next;
    logic [N_ATTR-1:0] tripped_reg, tripped_next;
    logic pf_reg, pf_next, pf_ev_reg, pf_ev_next;
    logic [7:0] pf_attr_reg, pf_attr_next;
    logic init_done_reg, init_done_next;

    // temperature state
    logic [47:0] ttimer_reg, ttimer_next;
    logic [7:0] temp_reg, temp_next;
    logic twarn_reg, twarn_next, tev_reg, tev_next;
    logic treq_reg, treq_next, frame_reg, frame_next;

    // sense state
    dhm_sense_t sense_reg, sense_next;
    logic sv_reg, sv_next;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= REG_HIST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [47:0] dec_wrap(input logic [47:0] v, input logic [47:0] n);
        dec_wrap = (v == 48'h0) ? n - 48'h1 : v - 48'h1;
    endfunction

    assign setup = psel & ~penable;
    assign acc = psel & penable & pready_reg;
    assign wr = acc & pwrite & mapped(paddr);
    assign clr_st = (wr && paddr == REG_STATUS) ? pwdata : 32'h0;

    // apb slave: answer registered in setup, write taken at access edge
    always_comb begin
        ctrl_next = ctrl_reg;
        ref_temp_next = ref_temp_reg;
        round_ev_next = 1'b0;
        rezero_next = 1'b0;
        round_flag_next = round_flag_reg & ~clr_st[ST_ROUND];
        pready_next = setup;
        pslverr_next = setup & ~mapped(paddr);
        prdata_next = prdata_reg;
        if (setup) begin
            case (paddr)
                REG_CTRL: prdata_next = {25'h0, ctrl_reg};
                REG_REF_TEMP: prdata_next = {24'h0, ref_temp_reg};
                REG_TEMP: prdata_next = {24'h0, temp_reg};
                REG_TIME_LO: prdata_next = mtimer_reg[31:0];
                REG_TIME_HI: prdata_next = {16'h0, mtimer_reg[47:32]};
                REG_STATUS: prdata_next = {23'h0, ms_reg == MS_RUN, sync_b, sync_a,
                    fail_b_reg, fail_a_reg, overrun_reg, round_flag_reg, twarn_reg, pf_reg};
                REG_SENSE: prdata_next = {8'h0, sense_reg};
                REG_HIST: prdata_next = hist_reg;
                default: prdata_next = 32'h0;
            endcase
        end
        if (wr) begin
            case (paddr)
                REG_CTRL: ctrl_next = pwdata[6:0];
                REG_CMD: rezero_next = pwdata[0];
                REG_REF_TEMP: begin
                    if (pwdata[7:0] > TRIP_FIXED || pwdata[31:8] != 24'h0) begin
                        ref_temp_next = TRIP_FIXED;
                        round_ev_next = 1'b1;
                    end else begin
                        ref_temp_next = pwdata[7:0];
                    end
                end
                default: ;
            endcase
        end
        if (round_ev_next) begin
            round_flag_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            ref_temp_reg <= REF_TEMP_RST;
            round_flag_reg <= 1'b0;
            round_ev_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            rezero_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            ref_temp_reg <= ref_temp_next;
            round_flag_reg <= round_flag_next;
            round_ev_reg <= round_ev_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            rezero_reg <= rezero_next;
        end
    end

    // link retry scheduler
    always_comb begin
        lk_next = lk_reg;
        retry_next = retry_reg;
        sel_b_next = sel_b_reg;
        fail_a_next = fail_a_reg;
        fail_b_next = fail_b_reg;
        lra_next = 1'b0;
        lrb_next = 1'b0;
        oob_next = 1'b0;
        rea_next = rea_reg;
        reb_next = reb_reg;
        case (lk_reg)
            LK_SELFTEST: begin
                if (selftest_done) begin
                    fail_a_next = selftest_fail_a;
                    fail_b_next = selftest_fail_b;
                    lk_next = LK_START;
                end
            end
            LK_START: begin
                rea_next = ~fail_a_reg;
                reb_next = ~fail_b_reg;
                lra_next = ~fail_a_reg;
                lrb_next = fail_a_reg & ~fail_b_reg;
                oob_next = ~(fail_a_reg & fail_b_reg);
                sel_b_next = ~fail_a_reg;
                retry_next = RETRY_CNT - 48'h1;
                lk_next = LK_RUN;
            end
            LK_RUN: begin
                retry_next = dec_wrap(retry_reg, RETRY_CNT);
                if (retry_reg == 48'h0) begin
                    // one port per tick, so each port sees every second tick
                    sel_b_next = ~sel_b_reg;
                    if (sel_b_reg) begin
                        lrb_next = ~fail_b_reg & ~sync_b;
                    end else begin
                        lra_next = ~fail_a_reg & ~sync_a;
                    end
                    oob_next = lra_next | lrb_next;
                end
            end
            default: lk_next = LK_SELFTEST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_reg <= LK_SELFTEST;
            retry_reg <= 48'h0;
            sel_b_reg <= 1'b0;
            fail_a_reg <= 1'b0;
            fail_b_reg <= 1'b0;
            lra_reg <= 1'b0;
            lrb_reg <= 1'b0;
            oob_reg <= 1'b0;
            rea_reg <= 1'b0;
            reb_reg <= 1'b0;
        end else begin
            lk_reg <= lk_next;
            retry_reg <= retry_next;
            sel_b_reg <= sel_b_next;
            fail_a_reg <= fail_a_next;
            fail_b_reg <= fail_b_next;
            lra_reg <= lra_next;
            lrb_reg <= lrb_next;
            oob_reg <= oob_next;
            rea_reg <= rea_next;
            reb_reg <= reb_next;
        end
    end

    // scheduled measure and save
    always_comb begin
        ms_next = ms_reg;
        mdelay_next = mdelay_reg;
        mstart_next = 1'b0;
        moff_next = moff_reg;
        overrun_next = overrun_reg & ~clr_st[ST_OVERRUN];
        mtimer_next = rezero_reg ? MEASURE_CNT - 48'h1
            : dec_wrap(mtimer_reg, MEASURE_CNT);
        case (ms_reg)
            MS_WAIT: begin
                if (!ctrl_reg.exception_monitor_disable) begin
                    if (rezero_reg) begin
                        ms_next = MS_RUN;
                        mstart_next = 1'b1;
                    end else if (mtimer_reg == 48'h0) begin
                        ms_next = MS_DUE;
                    end
                end
                mdelay_next = 48'h0;
                moff_next = ~ctrl_reg.online_only_select;
            end
            MS_DUE: begin
                if (ctrl_reg.exception_monitor_disable) begin
                    ms_next = MS_WAIT;
                end else if (host_idle || rezero_reg) begin
                    ms_next = MS_RUN;
                    mstart_next = 1'b1;
                end
                moff_next = ~ctrl_reg.online_only_select;
            end
            MS_RUN: begin
                // no abort path: the save runs until measure_done
                mdelay_next = mdelay_reg + 48'h1;
                if (mdelay_reg == (moff_reg ? FULL_DELAY_CNT : ONLINE_DELAY_CNT)) begin
                    overrun_next = 1'b1;
                end
                if (measure_done) begin
                    ms_next = MS_WAIT;
                end
            end
            default: ms_next = MS_WAIT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_reg <= MS_WAIT;
            mtimer_reg <= 48'h0;
            mdelay_reg <= 48'h0;
            overrun_reg <= 1'b0;
            mstart_reg <= 1'b0;
            moff_reg <= 1'b0;
        end else begin
            ms_reg <= ms_next;
            mtimer_reg <= mtimer_next;
            mdelay_reg <= mdelay_next;
            overrun_reg <= overrun_next;
            mstart_reg <= mstart_next;
            moff_reg <= moff_next;
        end
    end

    // error-rate monitor per attribute
    always_comb begin
        ivl_next = ivl_reg;
        fcnt_next = fcnt_reg;
        hist_next = hist_reg;
        tripped_next = tripped_reg;
        pf_ev_next = 1'b0;
        pf_attr_next = pf_attr_reg;
        init_done_next = 1'b1;
        for (int i = 0; i < N_ATTR; i++) begin
            if (!ctrl_reg.exception_monitor_disable) begin
                if (attr_op[i]) begin
                    ivl_next[i] = ivl_reg[i] + 16'h1;
                end
                if (attr_err[i] && fcnt_reg[i] != 16'hFFFF) begin
                    fcnt_next[i] = fcnt_reg[i] + 16'h1;
                end
                if (fcnt_next[i] > ATTR_ERR_THRESH) begin
                    ivl_next[i] = 16'h0;
                    fcnt_next[i] = 16'h0;
                    if (hist_reg[i] != HIST_MAX) begin
                        hist_next[i] = hist_reg[i] + 8'h1;
                    end
                end else if (ivl_next[i] >= ATTR_INTERVAL_LEN) begin
                    ivl_next[i] = 16'h0;
                    fcnt_next[i] = 16'h0;
                    if (hist_reg[i] != 8'h0) begin
                        hist_next[i] = hist_reg[i] - 8'h1;
                    end
                end
            end
            tripped_next[i] = hist_next[i] >= ATTR_PRED_THRESH;
            if (tripped_next[i] && !tripped_reg[i]) begin
                pf_ev_next = 1'b1;
                pf_attr_next = 8'(i);
            end
        end
        // set wins over the software clear; retained code caught after reset
        pf_next = (pf_reg & ~clr_st[ST_PF]) | pf_ev_next
            | (~init_done_reg & pf_retained);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ivl_reg <= '0;
            fcnt_reg <= '0;
            hist_reg <= '0;
            tripped_reg <= '0;
            pf_reg <= 1'b0;
            pf_ev_reg <= 1'b0;
            pf_attr_reg <= 8'h0;
            init_done_reg <= 1'b0;
        end else begin
            ivl_reg <= ivl_next;
            fcnt_reg <= fcnt_next;
            hist_reg <= hist_next;
            tripped_reg <= tripped_next;
            pf_reg <= pf_next;
            pf_ev_reg <= pf_ev_next;
            pf_attr_reg <= pf_attr_next;
            init_done_reg <= init_done_next;
        end
    end

    // thermal monitor; timer starts at zero so power-up samples at once
    always_comb begin
        ttimer_next = dec_wrap(ttimer_reg, TEMP_CNT);
        treq_next = ttimer_reg == 48'h0;
        temp_next = temp_reg;
        tev_next = 1'b0;
        frame_next = 1'b0;
        twarn_next = twarn_reg & ~clr_st[ST_TWARN];
        if (temp_valid) begin
            temp_next = temp_value;
            if (temp_value > TRIP_FIXED) begin
                frame_next = 1'b1;
            end
            if ((temp_value > TRIP_FIXED || temp_value > ref_temp_reg)
                && ctrl_reg.temperature_warning_enable) begin
                tev_next = 1'b1;
                twarn_next = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ttimer_reg <= 48'h0;
            treq_reg <= 1'b0;
            temp_reg <= 8'h0;
            tev_reg <= 1'b0;
            frame_reg <= 1'b0;
            twarn_reg <= 1'b0;
        end else begin
            ttimer_reg <= ttimer_next;
            treq_reg <= treq_next;
            temp_reg <= temp_next;
            tev_reg <= tev_next;
            frame_reg <= frame_next;
            twarn_reg <= twarn_next;
        end
    end

    // sense reporting; a zero method suppresses the pf and temperature reports, the rounding report still goes out
    always_comb begin
        sense_next = sense_reg;
        sv_next = 1'b0;
        if (pf_ev_reg && ctrl_reg.exception_report_method != 4'h0) begin
            sense_next = '{SENSE_PF | {8'h0, pf_attr_reg}, 8'h0};
            sv_next = 1'b1;
        end else if (tev_reg && ctrl_reg.exception_report_method != 4'h0) begin
            sense_next = '{SENSE_TEMP, temp_reg};
            sv_next = 1'b1;
        end else if (round_ev_reg) begin
            sense_next = '{SENSE_ROUND, 8'h0};
            sv_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_reg <= '0;
            sv_reg <= 1'b0;
        end else begin
            sense_reg <= sense_next;
            sv_reg <= sv_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign link_reset_a = lra_reg;
    assign link_reset_b = lrb_reg;
    assign link_oob = oob_reg;
    assign respond_en_a = rea_reg;
    assign respond_en_b = reb_reg;
    assign measure_start = mstart_reg;
    assign measure_offline = moff_reg;
    assign temp_sample_req = treq_reg;
    assign frame_store_req = frame_reg;
    assign pf_pending = pf_reg;
    assign sense_valid = sv_reg;
    assign sense_code = sense_reg.code;
    assign sense_fru = sense_reg.fru;

endmodule

// ### rtl/dhm_pkg.sv
// dhm_pkg: constants, register map and types of the drive health monitor.
// assumes a single 250 MHz clock domain and an apb register bus.
package dhm_pkg;

    // clock and times, each in its own unit
    localparam longint unsigned CLK_HZ = 64'd250000000;
    localparam longint unsigned RETRY_PERIOD_S = 64'd1;
    localparam longint unsigned PORT_RETRY_S = 64'd2;
    localparam longint unsigned MEASURE_PERIOD_MIN = 64'd120;
    localparam longint unsigned TEMP_PERIOD_MIN = 64'd10;
    localparam longint unsigned ONLINE_DELAY_MS = 64'd319;
    localparam longint unsigned FULL_DELAY_MS = 64'd364;

    // derived cycle counts; millisecond delays round down
    localparam logic [47:0] RETRY_CYCLES = 48'(CLK_HZ * RETRY_PERIOD_S);
    localparam logic [47:0] PORT_RETRY_CYCLES = 48'(CLK_HZ * PORT_RETRY_S);
    localparam logic [47:0] MEASURE_CYCLES = 48'(CLK_HZ * MEASURE_PERIOD_MIN * 64'd60);
    localparam logic [47:0] TEMP_CYCLES = 48'(CLK_HZ * TEMP_PERIOD_MIN * 64'd60);
    localparam logic [47:0] ONLINE_DELAY_CYCLES = 48'((CLK_HZ * ONLINE_DELAY_MS) / 64'd1000);
    localparam logic [47:0] FULL_DELAY_CYCLES = 48'((CLK_HZ * FULL_DELAY_MS) / 64'd1000);

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_REF_TEMP = 8'h08;
    localparam logic [7:0] REG_TEMP = 8'h0C;
    localparam logic [7:0] REG_TIME_LO = 8'h10;
    localparam logic [7:0] REG_TIME_HI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_SENSE = 8'h1C;
    localparam logic [7:0] REG_HIST = 8'h20;

    // status bit positions
    localparam int ST_PF = 0;
    localparam int ST_TWARN = 1;
    localparam int ST_ROUND = 2;
    localparam int ST_OVERRUN = 3;

    // attributes and their thresholds
    localparam int N_ATTR = 4;
    localparam logic [15:0] ATTR_INTERVAL_LEN = 16'h0400;
    localparam logic [15:0] ATTR_ERR_THRESH = 16'h0010;
    localparam logic [7:0] ATTR_PRED_THRESH = 8'h04;
    localparam logic [7:0] HIST_MAX = 8'hFF;

    // temperatures in degrees c
    localparam logic [7:0] TRIP_FIXED = 8'h41;
    localparam logic [7:0] REF_TEMP_RST = 8'h41;

    // sense codes: asc in the high byte, ascq in the low byte
    localparam logic [15:0] SENSE_PF = 16'h5D00;
    localparam logic [15:0] SENSE_TEMP = 16'h0B01;
    localparam logic [15:0] SENSE_ROUND = 16'h3700;

    typedef struct packed {
        logic [3:0] exception_report_method;
        logic temperature_warning_enable;
        logic online_only_select;
        logic exception_monitor_disable;
    } dhm_ctrl_t;

    localparam dhm_ctrl_t CTRL_RST = '{4'h0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [15:0] code;
        logic [7:0] fru;
    } dhm_sense_t;

    typedef enum logic [1:0] {
        LK_SELFTEST = 2'b00,
        LK_START = 2'b01,
        LK_RUN = 2'b10
    } dhm_link_t;

    typedef enum logic [1:0] {
        MS_WAIT = 2'b00,
        MS_DUE = 2'b01,
        MS_RUN = 2'b10
    } dhm_meas_t;

endpackage

// ### tb/dhm_props.sv
// dhm_props: port checker for dhm_top.
// assumes shortened counts handed on by the bind.
`timescale 1ns/1ns
module dhm_props
    import dhm_pkg::*;
#(
    parameter logic [47:0] RETRY_CNT = 48'h14,
    parameter logic [47:0] TEMP_CNT = 48'h64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic link_reset_a,
    input wire logic link_reset_b,
    input wire logic link_oob,
    input wire logic respond_en_a,
    input wire logic temp_valid,
    input wire logic [7:0] temp_value,
    input wire logic temp_sample_req,
    input wire logic frame_store_req,
    input wire logic pf_pending,
    input wire logic sense_valid,
    input wire logic [15:0] sense_code
);
    localparam int RT = int'(RETRY_CNT);
    localparam int TP = int'(TEMP_CNT);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_oob_with_reset: assert property (
        (link_reset_a || link_reset_b) |-> link_oob) else $error("reset without oob");
    a_failed_silent: assert property (
        link_reset_a |-> respond_en_a) else $error("reset on silent port");
    a_retry_alt: assert property (
        link_reset_a |-> !link_reset_b ##RT !link_reset_a) else $error("ports not alternating");
    a_retry_gap: assert property (
        (link_reset_a || link_reset_b) |=> !(link_reset_a || link_reset_b) [*8])
        else $error("retry too soon");
    a_temp_period: assert property (
        temp_sample_req |-> ##[1:TP] temp_sample_req) else $error("sample period");
    a_trip_frame: assert property (
        temp_valid && temp_value > TRIP_FIXED |-> ##[1:3] frame_store_req)
        else $error("no frame store");
    a_temp_sense: assert property (
        sense_valid && sense_code == SENSE_TEMP |-> $past(temp_valid, 2) || $past(temp_valid, 3))
        else $error("temp sense without sample");
    a_pf_sense: assert property (
        sense_valid && sense_code[15:8] == 8'h5D |-> $past(pf_pending))
        else $error("pf sense early");
    a_apb_answer: assert property (
        psel && !penable |=> pready ##1 !pready) else $error("apb answer");
    cover property (frame_store_req);
    cover property (sense_valid && sense_code == SENSE_TEMP);
    cover property (sense_valid && pf_pending);
endmodule

bind dhm_top dhm_props #(.RETRY_CNT(RETRY_CNT), .TEMP_CNT(TEMP_CNT)) u_props (.pclk, .presetn,
    .psel, .penable, .pready, .link_reset_a, .link_reset_b, .link_oob, .respond_en_a,
    .temp_valid, .temp_value, .temp_sample_req, .frame_store_req, .pf_pending, .sense_valid,
    .sense_code);

// ### tb/dhm_host_model.sv
// dhm_host_model: host controller on the two link ports.
// assumes one-cycle link reset pulses on pclk.
`timescale 1ns/1ns
module dhm_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_reset_a,
    input wire logic link_reset_b,
    input wire logic respond_en_a,
    input wire logic respond_en_b,
    input wire logic answer_a,
    input wire logic answer_b,
    output logic sync_a,
    output logic sync_b
);
    logic [3:0] pend_a, pend_b;
    // slow answer: sync five cycles after an answerable reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_a <= 4'h0;
            pend_b <= 4'h0;
            sync_a <= 1'h0;
            sync_b <= 1'h0;
        end else begin
            pend_a <= {pend_a[2:0], link_reset_a && respond_en_a};
            pend_b <= {pend_b[2:0], link_reset_b && respond_en_b};
            sync_a <= answer_a && (sync_a || pend_a[3]);
            sync_b <= answer_b && (sync_b || pend_b[3]);
        end
    end
endmodule

// ### tb/dhm_top_bench.sv
// dhm_top_bench: self-checking bench for dhm_top.
// assumes shortened counts; host model on the link pins.
`timescale 1ns/1ns
module dhm_top_bench
    import dhm_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00, temp_value = 8'h00, sense_fru;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic selftest_done = 1'h0, host_idle = 1'h1, measure_done = 1'h0, temp_valid = 1'h0;
    logic [3:0] attr_op = 4'h0, attr_err = 4'h0;
    logic pready, pslverr, err, sync_a, sync_b, link_reset_a, link_reset_b, link_oob;
    logic respond_en_a, respond_en_b, measure_start, measure_offline, temp_sample_req;
    logic frame_store_req, pf_pending, sense_valid, answer_a = 1'h0;
    logic fail_a = 1'h0, fail_b = 1'h1, pf_retained = 1'h0, answer_b = 1'h0;
    logic [15:0] sense_code;
    int bad_count = 0, n_compared = 0, n;
    dhm_top #(.RETRY_CNT(48'h14), .MEASURE_CNT(48'hC8), .TEMP_CNT(48'h64),
        .ONLINE_DELAY_CNT(48'hA), .FULL_DELAY_CNT(48'hF)) dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .selftest_done, .selftest_fail_a(fail_a), .selftest_fail_b(fail_b), .sync_a, .sync_b,
        .link_reset_a, .link_reset_b, .link_oob, .respond_en_a, .respond_en_b, .host_idle,
        .measure_start, .measure_offline, .measure_done, .attr_op, .attr_err, .temp_sample_req,
        .temp_valid, .temp_value, .frame_store_req, .pf_retained, .pf_pending,
        .sense_valid, .sense_code, .sense_fru);
    dhm_host_model host (.pclk, .presetn, .link_reset_a, .link_reset_b, .respond_en_a,
        .respond_en_b, .answer_a, .answer_b, .sync_a, .sync_b);
    always #2 pclk = ~pclk;
    // sensor and medium answer one cycle after each request, so runs stay short
    always @(posedge pclk) begin
        measure_done <= measure_start;
        temp_valid <= temp_sample_req;
    end
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (s !== 1'h1 && n < lim);
        if (s !== 1'h1) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic count_hi(ref logic s, input int len);
        n = 0;
        repeat (len) begin
            @(posedge pclk);
            n += int'(s === 1'h1);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        wait_hi(pready, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        selftest_done <= 1'h1;
        wait_hi(link_reset_a, 10);
        check(link_oob, 1'h1);
        check({respond_en_a, respond_en_b}, 2'h2);
        wait_hi(link_reset_a, 60);
        check(n, 40);
        answer_a <= 1'h1;
        count_hi(link_reset_a, 100);
        check(n, 0);
        apb(1'h0, REG_REF_TEMP, 32'h0);
        check(rd, 32'h41);
        apb(1'h1, REG_REF_TEMP, 32'h50);
        apb(1'h0, REG_REF_TEMP, 32'h0);
        check(rd, 32'h41);
        apb(1'h0, REG_STATUS, 32'h0);
        check(rd[ST_ROUND], 1'h1);
        apb(1'h1, REG_REF_TEMP, 32'h30);
        apb(1'h0, 8'h24, 32'h0);
        check(err, 1'h1);
        apb(1'h1, REG_CTRL, 32'h0E);
        temp_value <= 8'h46;
        wait_hi(sense_valid, 150);
        check({sense_code, sense_fru}, 24'h0B0146);
        temp_value <= 8'h40;
        apb(1'h0, REG_TEMP, 32'h0);
        check(rd, 32'h46);
        wait_hi(sense_valid, 150);
        check(sense_fru, 8'h40);
        temp_value <= 8'h20;
        for (int i = 1; i <= 4; i++) begin
            attr_err <= 4'h1;
            repeat (17) @(posedge pclk);
            attr_err <= 4'h0;
            if (i < 4) begin
                apb(1'h0, REG_HIST, 32'h0);
                check(rd[7:0], i);
            end
        end
        repeat (4) @(posedge pclk);
        check({pf_pending, sense_code}, 17'h15D00);
        attr_op <= 4'h1;
        repeat (1030) @(posedge pclk);
        attr_op <= 4'h0;
        apb(1'h0, REG_HIST, 32'h0);
        check(rd[7:0], 8'h3);
        wait_hi(measure_start, 250);
        apb(1'h1, REG_CMD, 32'h1);
        wait_hi(measure_start, 10);
        check(measure_offline, 1'h0);
        apb(1'h0, REG_TIME_LO, 32'h0);
        check(rd < 32'hC8 && rd > 32'hB4, 1'h1);
        apb(1'h1, REG_CTRL, 32'h1);
        apb(1'h1, REG_CMD, 32'h1);
        count_hi(measure_start, 300);
        check(n, 0);
        // second power-up: port a failed, retained failure, host answers on b
        presetn <= 1'h0;
        {fail_a, fail_b, pf_retained, answer_b} <= 4'hB;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        wait_hi(link_reset_b, 10);
        check({respond_en_a, respond_en_b, pf_pending}, 3'h3);
        count_hi(link_reset_b, 100);
        check(n, 0);
        stop_test();
    end
endmodule
